// ### common/qpc_pkg.sv
// Shared constants and types of the quad-phase core pipeline and memory map.
// Assumes one system clock standing for the oscillator input and 14-bit program words.
package qpc_pkg;

    // *************************************************************
    // Widths and vectors
    // *************************************************************
    localparam int          PC_W         = 13;
    localparam int          DATA_W       = 8;
    localparam int          INSTR_W      = 14;
    localparam int          EADDR_W      = 9;
    localparam logic [12:0] VEC_RESET    = 13'h0000;
    localparam logic [12:0] VEC_INT      = 13'h0004;
    localparam logic [12:0] PC_STEP      = 13'h0001;

    // *************************************************************
    // Register file offsets within a bank
    // *************************************************************
    localparam logic [6:0]  OFS_INDIRECT = 7'h00;
    localparam logic [6:0]  OFS_CNT_LOW  = 7'h02;
    localparam logic [6:0]  OFS_STATUS   = 7'h03;
    localparam logic [6:0]  OFS_POINTER  = 7'h04;
    localparam logic [6:0]  OFS_LATCH    = 7'h0A;
    localparam logic [6:0]  OFS_RAM_BASE = 7'h0C;

    // *************************************************************
    // Core status layout and reset values
    // *************************************************************
    localparam int          ST_BANK_HIGH = 6;
    localparam int          ST_BANK_LOW  = 5;
    localparam int          ST_ZERO      = 2;
    localparam logic [7:0]  STATUS_RESET = 8'h18;
    localparam logic [7:0]  STATUS_RO    = 8'h18;
    localparam logic [4:0]  LATCH_RESET  = 5'h00;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;

    // *************************************************************
    // Instruction encodings
    // *************************************************************
    localparam logic [13:0] NOP_WORD     = 14'h0000;
    localparam logic [2:0]  OP_JUMP      = 3'h5;
    localparam logic [6:0]  OP_MOVE_WF   = 7'h01;
    localparam logic [5:0]  OP_MOVE_FW   = 6'h08;
    localparam logic [3:0]  OP_LOAD_W    = 4'hC;

    // Phase of the instruction cycle.
    typedef enum logic [1:0] {
        QPC_PH1 = 2'b00,
        QPC_PH2 = 2'b01,
        QPC_PH3 = 2'b10,
        QPC_PH4 = 2'b11
    } qpc_phase_t;

endpackage : qpc_pkg

// ### common/qpc_ram_if.sv
// Port bundle between the core and its general RAM.
// Assumes both ends run on the same clock.
interface qpc_ram_if #(parameter int AW = 7);
    logic [AW-1:0] addr;
    logic          rdEn;
    logic          wrEn;
    logic [7:0]    wrData;
    logic [7:0]    rdData;

    modport core (output addr, output rdEn, output wrEn, output wrData, input rdData);
    modport mem  (input addr, input rdEn, input wrEn, input wrData, output rdData);
endinterface : qpc_ram_if

// ### core/qpc_ram.sv
// General RAM of the data map, one byte per location, registered read data.
// Assumes read and write strobes come on distinct phases of the core.
module qpc_ram
    import qpc_pkg::*;
#(
    parameter int DEPTH = 68
) (
    // Clock
    input wire logic clk_sys,
    // Core side
    qpc_ram_if.mem   bus
);

    logic [7:0] cells [DEPTH];
    logic [7:0] rdData;

    // Writes store a byte, reads register the addressed byte.
    always_ff @(posedge clk_sys) begin
        if (bus.wrEn) begin
            cells[bus.addr] <= bus.wrData;
        end
        if (bus.rdEn) begin
            rdData <= cells[bus.addr];
        end
    end

    assign bus.rdData = rdData;

endmodule : qpc_ram

// ### core/qpc_core.sv
// Quad-phase core timing, two-stage pipeline and banked data memory map.
// Assumes program memory answers combinationally to progAddr within the cycle.
// What this block does
// [RL1] Divide the input clock into four non-overlapping phases per instruction cycle.
// [RL2] Program counter advances once per instruction cycle, at phase one.
// [RL3] Fetched word is captured into the instruction register at phase four.
// [RL4] Captured instruction is presented at phase one, executed in phases two to four.
// [RL5] Operand read happens in phase two, destination write in phase four.
// [RL6] Fetch overlaps execution, one plain instruction per cycle.
// [RL7] A counter change discards the fetched word, costing two cycles.
// [RL8] Program memory and data memory use separate buses.
// [RL9] Thirteen-bit counter spans an 8K word space of 14-bit words.
// [RL10] Only 512 or 1K words exist; higher addresses wrap.
// [RL11] Counter loads 0000h on reset and 0004h on interrupt.
// [RL12] Bank select low bit picks bank zero or bank one.
// [RL13] Banks span 128 bytes; first twelve are special registers, next 68 are RAM.
// [RL14] Bank one general RAM maps onto the same bank zero cells.
// [RL15] Indirect addresses combine the pointer with the high bank select bit.
// [RL16] Each general RAM byte is reachable directly or through the pointer.
// [RL17] The 64-byte data EEPROM is absent from the direct data map.
// [RL18] Instructions move working register to any file location and back.
// [RL19] Unimplemented data locations read as zero.
// [RL20] Upper counter bits come from a latch and are never copied back.
// [RL21] The indirect access location redirects to the pointer and stores nothing.
// [RL22] A flushed cycle executes as a no-operation.
module qpc_core
    import qpc_pkg::*;
#(
    parameter int PROG_WORDS = 1024,
    parameter int RAM_BYTES  = 68
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // Program memory bus
    output logic [PC_W-1:0]         progAddr,
    input  wire logic [INSTR_W-1:0] progData,
    // Interrupt request
    input  wire logic               intReq,
    // Phase outputs and core state
    output logic                    phaseOne,
    output logic                    phaseTwo,
    output logic                    phaseThree,
    output logic                    phaseFour,
    output logic [DATA_W-1:0]       working
);

    localparam int          RAM_AW    = $clog2(RAM_BYTES);
    localparam logic [12:0] PROG_MASK = 13'(PROG_WORDS - 1);
    localparam logic [6:0]  RAM_TOP   = 7'(RAM_BYTES);

    // *************************************************************
    // Reset release
    // *************************************************************
    logic [1:0] rstPipe;
    logic       rstSync;

    // Two flops release the reset synchronously.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync = rstPipe[1];

    // *************************************************************
    // Phase generator
    // *************************************************************
    qpc_phase_t ph, next_ph;
    logic [3:0] next_phases;

    // [RL1] Divide by four.
    always_comb begin
        unique case (ph)
            QPC_PH1: next_ph = QPC_PH2;
            QPC_PH2: next_ph = QPC_PH3;
            QPC_PH3: next_ph = QPC_PH4;
            QPC_PH4: next_ph = QPC_PH1;
        endcase
        next_phases = 4'h1 << next_ph;
    end

    // Phase state and its one-hot copy on the outputs.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            ph <= QPC_PH1;
            {phaseFour, phaseThree, phaseTwo, phaseOne} <= 4'h1;
        end else begin
            ph <= next_ph;
            {phaseFour, phaseThree, phaseTwo, phaseOne} <= next_phases;
        end
    end

    // *************************************************************
    // Data address decode
    // *************************************************************
    logic [PC_W-1:0]    pc;
    logic [INSTR_W-1:0] instr;
    logic [7:0]         status;
    logic [7:0]         pointer;
    logic [4:0]         latch;
    logic [7:0]         operand;
    logic [EADDR_W-1:0] effAddr;
    logic [6:0]         offset;
    logic               inRam;
    logic               unimpl;
    logic [7:0]         specRead;

    // [RL12] Bank bit selection.
    // Builds the 9-bit data address from bank bits and file field or pointer.
    function automatic logic [EADDR_W-1:0] effective(input logic [6:0] field,
                                                     input logic [7:0] stat,
                                                     input logic [7:0] ptr);
        logic [EADDR_W-1:0] ea;
        ea = {stat[ST_BANK_HIGH], stat[ST_BANK_LOW], field};
        if (field == OFS_INDIRECT) begin
            ea = {stat[ST_BANK_HIGH], ptr};
        end
        return ea;
    endfunction

    qpc_ram_if #(.AW(RAM_AW)) ramBus ();

    // [RL15] Indirect address from pointer and high bank bit.
    always_comb begin
        effAddr = effective(instr[6:0], status, pointer);
        offset  = effAddr[6:0];
        // [RL14] Both banks share general RAM cells.
        inRam   = !effAddr[EADDR_W-1] && (offset >= OFS_RAM_BASE)
                  && ((offset - OFS_RAM_BASE) < RAM_TOP);
        unimpl  = effAddr[EADDR_W-1];
        // [RL13] Low twelve offsets decode to special registers.
        // [RL17] The EEPROM has no place in this map.
        specRead = BYTE_ZERO;
        if (!unimpl) begin
            unique case (offset)
                OFS_CNT_LOW: specRead = pc[7:0];
                OFS_STATUS:  specRead = status;
                OFS_POINTER: specRead = pointer;
                OFS_LATCH:   specRead = {3'h0, latch};
                // [RL19] Anything else reads zero.
                default:     specRead = BYTE_ZERO;
            endcase
        end
    end

    // *************************************************************
    // Execute decode
    // *************************************************************
    logic       isJump;
    logic       isMoveWf;
    logic       isMoveFw;
    logic       isLoadW;
    logic       writesFile;
    logic [7:0] writeData;
    logic       lowWrite;
    logic       takeBranch;
    logic       takeInt;

    // [RL18] Moves between working register and file.
    always_comb begin
        isJump     = instr[13:11] == OP_JUMP;
        isMoveWf   = instr[13:7] == OP_MOVE_WF;
        isMoveFw   = instr[13:8] == OP_MOVE_FW;
        isLoadW    = instr[13:10] == OP_LOAD_W;
        writesFile = isMoveWf || (isMoveFw && instr[7]);
        writeData  = isMoveWf ? working : operand;
        lowWrite   = writesFile && !unimpl && (offset == OFS_CNT_LOW);
        takeBranch = (ph == QPC_PH4) && (isJump || lowWrite);
        takeInt    = (ph == QPC_PH4) && intReq && !takeBranch;
    end

    // [RL5] RAM read in phase two, write in phase four.
    // [RL8] Data RAM has its own bus apart from program memory.
    // [RL16] Direct or indirect bytes.
    assign ramBus.addr   = inRam ? RAM_AW'(offset - OFS_RAM_BASE) : '0;
    assign ramBus.rdEn   = ph == QPC_PH2;
    assign ramBus.wrEn   = (ph == QPC_PH4) && writesFile && inRam;
    assign ramBus.wrData = writeData;

    qpc_ram #(.DEPTH(RAM_BYTES)) generalRam (
        .clk_sys (clk_sys),
        .bus     (ramBus)
    );

    // *************************************************************
    // Pipeline and program counter
    // *************************************************************
    logic [PC_W-1:0]    next_pc;
    logic [PC_W-1:0]    next_progAddr;
    logic [INSTR_W-1:0] next_instr;
    logic [7:0]         next_operand;

    always_comb begin
        next_pc      = pc;
        next_instr   = instr;
        next_operand = operand;
        // [RL5] Operand captured after the phase two read.
        if (ph == QPC_PH3) begin
            next_operand = inRam ? ramBus.rdData : specRead;
        end
        if (ph == QPC_PH4) begin
            // [RL2] Step once per cycle into phase one.
            next_pc    = pc + PC_STEP;
            // [RL3] Capture fetched word; [RL4] it runs next cycle.
            // [RL6] Fetch of the next word overlaps this execution.
            next_instr = progData;
            if (takeBranch) begin
                // [RL20] Upper bits come from the latch only.
                next_pc    = isJump ? {latch[4:3], instr[10:0]} : {latch, writeData};
                // [RL7] Discard the fetched word; [RL22] run a no-operation.
                next_instr = NOP_WORD;
            end else if (takeInt) begin
                // [RL11] Interrupt vector.
                next_pc    = VEC_INT;
                next_instr = NOP_WORD;
            end
        end
        // [RL9] [RL10] Only low address bits reach program memory.
        next_progAddr = next_pc & PROG_MASK;
    end

    // Pipeline registers.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            // [RL11] Reset vector.
            pc       <= VEC_RESET;
            progAddr <= VEC_RESET;
            instr    <= NOP_WORD;
            operand  <= BYTE_ZERO;
        end else begin
            pc       <= next_pc;
            progAddr <= next_progAddr;
            instr    <= next_instr;
            operand  <= next_operand;
        end
    end

    // *************************************************************
    // Core registers and working register
    // *************************************************************
    logic [7:0] next_status;
    logic [7:0] next_pointer;
    logic [4:0] next_latch;
    logic [7:0] next_working;

    // Destination writes land in phase four.
    always_comb begin
        next_status  = status;
        next_pointer = pointer;
        next_latch   = latch;
        next_working = working;
        if (ph == QPC_PH4) begin
            // [RL21] Indirect location stores nothing; writes go via pointer.
            if (writesFile && !unimpl) begin
                unique case (offset)
                    OFS_STATUS:  next_status  = (writeData & ~STATUS_RO) | STATUS_RO;
                    OFS_POINTER: next_pointer = writeData;
                    OFS_LATCH:   next_latch   = writeData[4:0];
                    default:     next_status  = status;
                endcase
            end
            if (isMoveFw) begin
                next_status[ST_ZERO] = operand == BYTE_ZERO;
                if (!instr[7]) begin
                    next_working = operand;
                end
            end
            if (isLoadW) begin
                next_working = instr[7:0];
            end
        end
    end

    // Core register state.
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            status  <= STATUS_RESET;
            pointer <= BYTE_ZERO;
            latch   <= LATCH_RESET;
            working <= BYTE_ZERO;
        end else begin
            status  <= next_status;
            pointer <= next_pointer;
            latch   <= next_latch;
            working <= next_working;
        end
    end

    // *************************************************************
    // Checks
    // *************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstSync);

    // One full instruction cycle of phases, started after a phase four.
    // Phase one stands for several clocks while reset is released, so it cannot lead.
    sequence phaseWalk;
        phaseOne ##1 phaseTwo ##1 phaseThree ##1 phaseFour;
    endsequence

    // The discarded word stays a no-operation for one whole instruction cycle.
    sequence flushSlot;
        (instr == NOP_WORD) [*4];
    endsequence

    chk_phase_onehot: assert property ($onehot({phaseOne, phaseTwo, phaseThree, phaseFour})) // [RL1]
        else $error("phases overlap");
    chk_phase_order: assert property (phaseFour |=> phaseWalk) // [RL1]
        else $error("phase order broken");
    chk_pc_step: assert property (phaseFour && !takeBranch && !takeInt |=> pc == $past(pc) + PC_STEP) // [RL2]
        else $error("counter did not step");
    chk_pc_hold: assert property (!phaseFour |=> $stable(pc)) // [RL2]
        else $error("counter moved outside phase one");
    chk_branch_flush: assert property (takeBranch |=> flushSlot) // [RL7]
        else $error("fetched word not discarded");
    chk_flush_idle: assert property (takeBranch |=> ##4 $stable(working) // [RL22]
                                     && $stable(pointer) && $stable(latch))
        else $error("flushed cycle changed state");
    chk_int_vector: assert property (takeInt |=> pc == VEC_INT) // [RL11]
        else $error("interrupt vector wrong");
    chk_write_phase: assert property (ramBus.wrEn |-> phaseFour && ph == QPC_PH4) // [RL5]
        else $error("data write outside phase four");
    chk_prog_wrap: assert property (progAddr == (pc & PROG_MASK)) // [RL10]
        else $error("program address not wrapped");
    chk_unimpl_zero: assert property (ph == QPC_PH3 && unimpl |=> operand == BYTE_ZERO) // [RL19]
        else $error("unimplemented location not zero");

endmodule : qpc_core

// ### verification/qpc_prog_model.sv
// Program memory model that answers the core's fetch address within the same cycle.
// Assumes the testbench fills the word array before it resets the core.
module qpc_prog_model
    import qpc_pkg::*;
#(
    parameter int PROG_WORDS = 1024
) (
    // Fetch bus
    input  wire logic [PC_W-1:0] progAddr,
    output logic [INSTR_W-1:0]   progData
);
    timeunit 1ns;
    timeprecision 1ps;

    // Word storage, written directly by the testbench.
    logic [INSTR_W-1:0] mem [PROG_WORDS];

    // own bus, wrapping
    // Only the low address bits pick a word, so addresses above the array wrap.
    assign progData = mem[progAddr % PROG_WORDS];
endmodule // qpc_prog_model

// ### verification/qpc_tb_top.sv
// Self-checking testbench of the quad-phase core: runs small programs and checks results.
// Assumes the program model answers combinationally and each program ends in a jump to itself.
module qpc_tb_top
    import qpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam int PW = 1024;
    logic                clk_sys;
    logic                rst_n;
    logic [PC_W-1:0]     progAddr;
    logic [INSTR_W-1:0]  progData;
    logic                intReq;
    logic                phaseOne;
    logic                phaseTwo;
    logic                phaseThree;
    logic                phaseFour;
    logic [DATA_W-1:0]   working;
    logic [PC_W-1:0]     trace [$];
    int                  failures;
    int                  checked;

    qpc_core #(.PROG_WORDS(PW), .RAM_BYTES(68)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .progAddr(progAddr), .progData(progData),
        .intReq(intReq), .phaseOne(phaseOne), .phaseTwo(phaseTwo),
        .phaseThree(phaseThree), .phaseFour(phaseFour), .working(working));

    qpc_prog_model #(.PROG_WORDS(PW)) prog (.progAddr(progAddr), .progData(progData));

    // Free-running 125 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ************************************************************
    // Instruction words and helpers
    // ************************************************************
    function automatic logic [13:0] lw(input logic [7:0] k);
        return {OP_LOAD_W, 2'b00, k};
    endfunction
    function automatic logic [13:0] mwf(input logic [6:0] f);
        return {OP_MOVE_WF, f};
    endfunction
    function automatic logic [13:0] mfw(input logic [6:0] f);
        return {OP_MOVE_FW, 1'b0, f};
    endfunction
    function automatic logic [13:0] jmp(input logic [10:0] k);
        return {OP_JUMP, k};
    endfunction

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Clears program memory, then places the words from address zero.
    task automatic load(input logic [13:0] w [$]);
        for (int i = 0; i < PW; i++) begin
            prog.mem[i] = NOP_WORD;
        end
        foreach (w[i]) begin
            prog.mem[i] = w[i];
        end
    endtask

    // Resets the core, runs fifty instruction cycles, checks phases and the result.
    task automatic run_prog(input string name, input int intAt, input logic [7:0] expW);
        logic [3:0] cur;
        logic [3:0] lastPh;
        logic       started;
        logic       newCycle;
        logic       intDone;
        trace.delete();
        lastPh = 4'b1000;
        started = 1'b0;
        newCycle = 1'b1;
        intDone = 1'b0;
        intReq = 1'b0;
        rst_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        check("reset phases", 16'h0008, {12'h000, phaseOne, phaseTwo, phaseThree, phaseFour});
        check("reset address", 16'h0000, {3'b000, progAddr});
        check("reset working", 16'h0000, {8'h00, working});
        rst_n = 1'b1;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            #1;
            cur = {phaseOne, phaseTwo, phaseThree, phaseFour};
            if (cur === 4'b0100) begin
                started = 1'b1;
            end
            if (started) begin
                check("phase", {12'h000, lastPh[0], lastPh[3:1]}, {12'h000, cur});
            end
            lastPh = cur;
            if (cur === 4'b1000 && newCycle) begin
                trace.push_back(progAddr);
                newCycle = 1'b0;
            end
            if (cur === 4'b0001) begin
                newCycle = 1'b1;
            end
            if (intReq === 1'b1 && progAddr === VEC_INT) begin
                intReq = 1'b0;
                intDone = 1'b1;
            end else if (intAt > 0 && !intDone && trace.size() == intAt) begin
                intReq = 1'b1;
            end
        end
        check({"working after ", name}, {8'h00, expW}, {8'h00, working});
        $display("done %s", name);
    endtask

    // Compares the first five fetch addresses seen at phase one.
    task automatic chk_trace(input logic [12:0] exp [5]);
        for (int i = 0; i < 5; i++) begin
            check("fetch address", {3'b000, exp[i]}, {3'b000, trace[i]});
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    // Main sequence of programs.
    initial begin
        logic [6:0] unimpl [6];
        unimpl = '{7'h07, 7'h50, 7'h7F, 7'h01, 7'h08, 7'h0B};
        failures = 0;
        checked = 0;
        load('{lw(8'h5A), mwf(7'h0C), lw(8'h00), mfw(7'h0C), jmp(11'h004)});
        run_prog("move and reload", 0, 8'h5A);
        chk_trace('{13'h0000, 13'h0001, 13'h0002, 13'h0003, 13'h0004});
        load('{lw(8'hA5), mwf(7'h4F), lw(8'h20), mwf(7'h03), lw(8'h00), mfw(7'h4F), jmp(11'h006)});
        run_prog("bank one mirror", 0, 8'hA5);
        load('{lw(8'h20), mwf(7'h03), mfw(7'h03), jmp(11'h003)});
        run_prog("status bank bit", 0, 8'h38);
        load('{lw(8'h3C), mwf(7'h10), lw(8'h90), mwf(7'h04), lw(8'h00), mfw(7'h00), jmp(11'h006)});
        run_prog("indirect read", 0, 8'h3C);
        load('{lw(8'h90), mwf(7'h04), lw(8'h77), mwf(7'h00), lw(8'h00), mfw(7'h10), jmp(11'h006)});
        run_prog("indirect write", 0, 8'h77);
        foreach (unimpl[i]) begin
            load('{lw(8'hFF), mwf(unimpl[i]), lw(8'h11), mfw(unimpl[i]), jmp(11'h004)});
            run_prog("unimplemented read", 0, 8'h00);
        end
        load('{lw(8'h42), jmp(11'h004), lw(8'hFF), lw(8'hEE), jmp(11'h004)});
        run_prog("jump flush", 0, 8'h42);
        chk_trace('{13'h0000, 13'h0001, 13'h0002, 13'h0004, 13'h0005});
        load('{lw(8'h18), mwf(7'h0A), jmp(11'h020), lw(8'hEE)});
        prog.mem[32] = lw(8'h00);
        prog.mem[33] = mfw(7'h0A);
        prog.mem[34] = jmp(11'h022);
        run_prog("latch jump wrap", 0, 8'h18);
        chk_trace('{13'h0000, 13'h0001, 13'h0002, 13'h0003, 13'h0020});
        load('{lw(8'h01), jmp(11'h001), NOP_WORD, NOP_WORD, lw(8'h66), jmp(11'h005)});
        run_prog("interrupt vector", 4, 8'h66);
        chk_trace('{13'h0000, 13'h0001, 13'h0002, 13'h0001, 13'h0004});
        // A write to the low count byte branches like a jump and flushes one word.
        load('{lw(8'h04), mwf(7'h02), lw(8'hEE), lw(8'hDD), lw(8'h3A), jmp(11'h005)});
        run_prog("count low write", 0, 8'h3A);
        chk_trace('{13'h0000, 13'h0001, 13'h0002, 13'h0004, 13'h0005});
        // A file-to-file move of zero sets the zero flag, seen through the status byte.
        load('{lw(8'h00), mwf(7'h0C), {OP_MOVE_FW, 1'b1, 7'h0C}, mfw(7'h03), jmp(11'h004)});
        run_prog("file to file zero", 0, 8'h1C);
        // With the high bank bit set, the data map reads zero.
        load('{lw(8'h77), mwf(7'h0C), lw(8'h40), mwf(7'h03), lw(8'h99), mfw(7'h0C), jmp(11'h006)});
        run_prog("high bank zero", 0, 8'h00);
        print_verdict();
    end

    // Cuts a hang short well beyond the expected run time.
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
endmodule // qpc_tb_top
